//--- core/bpb_gpio_ports.sv
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "bpb_map.svh"
// Overview of operation
// - Port A pullup enable 1 connects pin pullup while input; 0 disconnects.
// - Port A pullup forced off whenever the pin direction is output.
// - Port B has eight read/write data latches at index 1, unaffected by reset.
// - Converter channel select forces its port B pin to analog input.
// - Unselected port B pins act as normal digital I/O.
// - Port B direction 1 enables output buffer, 0 makes pin an input.
// - Reset clears all port B direction bits.
// - Port B read returns latch for outputs, pin level for inputs.
// - Data writes with byte lane 0 strobed update latch, whatever the direction; input pins still read pin level.
// - Port C has seven data latches unaffected by reset.
// - Port C direction 1 drives, 0 inputs; reset clears all seven.
// - Port C read returns latch for outputs, pin level for inputs.
// - Port C pullup enable 1 connects pullup while input; 0 disconnects.
// - Port C pullup forced off whenever the pin direction is output.
// - Port B has no pullup control at all.
module bpb_gpio_ports
    import bpb_pkg::*;
#(
    parameter int PORT_C_WIDTH = 7,
    parameter int ADC_CH_WIDTH = 5
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    // AXI4-Lite write address and data
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    // AXI4-Lite read
    input wire logic [31:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Neighbouring logic
    input wire logic [7:0] port_a_direction_in,
    input wire logic [ADC_CH_WIDTH-1:0] adc_channel_in,
    // Port A pullups
    output logic [7:0] port_a_pullup_out,
    // Port B pins
    input wire logic [7:0] port_b_pin_in,
    output logic [7:0] port_b_pin_out,
    output logic [7:0] port_b_pin_oe_n_out,
    output logic [7:0] converter_analog_inputs_out,
    // Port C pins
    input wire logic [PORT_C_WIDTH-1:0] port_c_pin_in,
    output logic [PORT_C_WIDTH-1:0] port_c_pin_out,
    output logic [PORT_C_WIDTH-1:0] port_c_pin_oe_n_out,
    output logic [PORT_C_WIDTH-1:0] port_c_pullup_out
);

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    if (PORT_C_WIDTH < 1 || PORT_C_WIDTH > 8) begin : g_bad_c
        $error("PORT_C_WIDTH must lie in 1 to 8");
    end
    if (ADC_CH_WIDTH < 3 || ADC_CH_WIDTH > 8) begin : g_bad_ch
        $error("ADC_CH_WIDTH must lie in 3 to 8");
    end

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function automatic bpb_sel_type reg_select(input logic [31:0] addr);
        logic [5:0] idx;
        idx = addr[7:2];
        if (addr[31:8] != 24'h00_0000) begin
            reg_select = BPB_SEL_NONE;
        end else if (idx == `BPB_IDX_PORT_B_DATA) begin
            reg_select = BPB_SEL_B_DATA;
        end else if (idx == `BPB_IDX_PORT_C_DATA) begin
            reg_select = BPB_SEL_C_DATA;
        end else if (idx == `BPB_IDX_PORT_B_DIR) begin
            reg_select = BPB_SEL_B_DIR;
        end else if (idx == `BPB_IDX_PORT_C_DIR) begin
            reg_select = BPB_SEL_C_DIR;
        end else if (idx == `BPB_IDX_PORT_A_PUE) begin
            reg_select = BPB_SEL_A_PUE;
        end else if (idx == `BPB_IDX_PORT_C_PUE) begin
            reg_select = BPB_SEL_C_PUE;
        end else begin
            reg_select = BPB_SEL_NONE;
        end
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [7:0] port_b_data_latch_reg;
    logic [PORT_C_WIDTH-1:0] port_c_data_latch_reg;
    logic [7:0] port_b_direction_reg;
    logic [PORT_C_WIDTH-1:0] port_c_direction_reg;
    logic [7:0] port_a_pullup_enable_reg;
    logic [PORT_C_WIDTH-1:0] port_c_pullup_enable_reg;
    logic [7:0] pin_b_meta_reg;
    logic [7:0] pin_b_sync_reg;
    logic [PORT_C_WIDTH-1:0] pin_c_meta_reg;
    logic [PORT_C_WIDTH-1:0] pin_c_sync_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [31:0] awaddr_reg;
    bpb_wdata_type wreq_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic [7:0] pin_b_oe_n_reg;
    logic [PORT_C_WIDTH-1:0] pin_c_oe_n_reg;
    logic [7:0] analog_sel_reg;
    logic [7:0] pullup_a_reg;
    logic [PORT_C_WIDTH-1:0] pullup_c_reg;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_write;
    logic aw_held_next;
    logic w_held_next;
    logic wr_lane0;
    bpb_sel_type wr_sel;
    bpb_sel_type rd_sel;
    logic [7:0] analog_next;
    logic [7:0] rd_b_data;
    logic [7:0] rd_c_data;
    logic [31:0] rdata_next;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        pin_b_meta_reg <= port_b_pin_in;
        pin_b_sync_reg <= pin_b_meta_reg;
        pin_c_meta_reg <= port_c_pin_in;
        pin_c_sync_reg <= pin_c_meta_reg;
    end

    // ----------------------------------------------------------------
    // Write channel
    // ----------------------------------------------------------------
    // Address and data may arrive in either order; each is held until both are in.
    assign aw_take = s_axi_awvalid_in && awready_reg;
    assign w_take = s_axi_wvalid_in && wready_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign aw_held_next = aw_held_reg ? !do_write : aw_take;
    assign w_held_next = w_held_reg ? !do_write : w_take;
    assign wr_sel = reg_select(awaddr_reg);
    assign wr_lane0 = do_write && wreq_reg.strb[0];

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wreq_reg <= '0;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awready_reg <= !aw_held_next;
            wready_reg <= !w_held_next;
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr_in;
            end
            if (w_take) begin
                wreq_reg <= '{data: s_axi_wdata_in, strb: s_axi_wstrb_in};
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= `BPB_RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wr_sel == BPB_SEL_NONE) ? `BPB_RESP_SLVERR : `BPB_RESP_OKAY;
        end else if (s_axi_bready_in) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Data latches
    // ----------------------------------------------------------------
    // No reset here: the latches keep their contents across reset.
    always_ff @(posedge clk_sys_in) begin
        if (wr_lane0 && wr_sel == BPB_SEL_B_DATA) begin
            port_b_data_latch_reg <= wreq_reg.data[7:0];
        end
        if (wr_lane0 && wr_sel == BPB_SEL_C_DATA) begin
            port_c_data_latch_reg <= wreq_reg.data[PORT_C_WIDTH-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Direction and pullup enables
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            port_b_direction_reg <= `BPB_RST_DIR;
            port_c_direction_reg <= PORT_C_WIDTH'(`BPB_RST_DIR);
            port_a_pullup_enable_reg <= `BPB_RST_PUE;
            port_c_pullup_enable_reg <= PORT_C_WIDTH'(`BPB_RST_PUE);
        end else if (wr_lane0) begin
            if (wr_sel == BPB_SEL_B_DIR) begin
                port_b_direction_reg <= wreq_reg.data[7:0];
            end
            if (wr_sel == BPB_SEL_C_DIR) begin
                port_c_direction_reg <= wreq_reg.data[PORT_C_WIDTH-1:0];
            end
            if (wr_sel == BPB_SEL_A_PUE) begin
                port_a_pullup_enable_reg <= wreq_reg.data[7:0];
            end
            if (wr_sel == BPB_SEL_C_PUE) begin
                port_c_pullup_enable_reg <= wreq_reg.data[PORT_C_WIDTH-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read channel
    // ----------------------------------------------------------------
    assign ar_take = s_axi_arvalid_in && arready_reg;
    assign rd_sel = reg_select(s_axi_araddr_in);
    assign rd_b_data = (port_b_direction_reg & port_b_data_latch_reg)
        | (~port_b_direction_reg & pin_b_sync_reg);
    assign rd_c_data = 8'((port_c_direction_reg & port_c_data_latch_reg)
        | (~port_c_direction_reg & pin_c_sync_reg));

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (rd_sel == BPB_SEL_B_DATA) begin
            rdata_next[7:0] = rd_b_data;
        end else if (rd_sel == BPB_SEL_C_DATA) begin
            rdata_next[7:0] = rd_c_data;
        end else if (rd_sel == BPB_SEL_B_DIR) begin
            rdata_next[7:0] = port_b_direction_reg;
        end else if (rd_sel == BPB_SEL_C_DIR) begin
            rdata_next[7:0] = 8'(port_c_direction_reg);
        end else if (rd_sel == BPB_SEL_A_PUE) begin
            rdata_next[7:0] = port_a_pullup_enable_reg;
        end else if (rd_sel == BPB_SEL_C_PUE) begin
            rdata_next[7:0] = 8'(port_c_pullup_enable_reg);
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rresp_reg <= `BPB_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else begin
            arready_reg <= !ar_take && (!rvalid_reg || s_axi_rready_in);
            if (ar_take) begin
                rvalid_reg <= 1'b1;
                rdata_reg <= rdata_next;
                rresp_reg <= (rd_sel == BPB_SEL_NONE) ? `BPB_RESP_SLVERR : `BPB_RESP_OKAY;
            end else if (s_axi_rready_in) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin control
    // ----------------------------------------------------------------
    // Only channel numbers below eight reach a port B pin; others are internal.
    generate
        for (genvar i = 0; i < `BPB_ADC_PINS; i++) begin : g_analog
            assign analog_next[i] = (adc_channel_in == ADC_CH_WIDTH'(i));
        end
    endgenerate

    // Drive and pullup controls cost one cycle of latency after the register write.
    always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
            pin_b_oe_n_reg <= `BPB_RST_OE_N;
            pin_c_oe_n_reg <= PORT_C_WIDTH'(`BPB_RST_OE_N);
            analog_sel_reg <= 8'h00;
            pullup_a_reg <= 8'h00;
            pullup_c_reg <= '0;
        end else begin
            pin_b_oe_n_reg <= ~(port_b_direction_reg & ~analog_next);
            pin_c_oe_n_reg <= ~port_c_direction_reg;
            analog_sel_reg <= analog_next;
            pullup_a_reg <= port_a_pullup_enable_reg & ~port_a_direction_in;
            pullup_c_reg <= port_c_pullup_enable_reg & ~port_c_direction_reg;
        end
    end

    // Port B carries no pullup output at all.
    assign port_b_pin_out = port_b_data_latch_reg;
    assign port_b_pin_oe_n_out = pin_b_oe_n_reg;
    assign converter_analog_inputs_out = analog_sel_reg;
    assign port_c_pin_out = port_c_data_latch_reg;
    assign port_c_pin_oe_n_out = pin_c_oe_n_reg;
    assign port_c_pullup_out = pullup_c_reg;
    assign port_a_pullup_out = pullup_a_reg;
    assign s_axi_awready_out = awready_reg;
    assign s_axi_wready_out = wready_reg;
    assign s_axi_bvalid_out = bvalid_reg;
    assign s_axi_bresp_out = bresp_reg;
    assign s_axi_arready_out = arready_reg;
    assign s_axi_rvalid_out = rvalid_reg;
    assign s_axi_rdata_out = rdata_reg;
    assign s_axi_rresp_out = rresp_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_dir_b_write;
        wr_lane0 && wr_sel == BPB_SEL_B_DIR;
    endsequence

    sequence s_read_b;
        ar_take && rd_sel == BPB_SEL_B_DATA;
    endsequence

    pullup_a_off_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        ##1 ((port_a_pullup_out & $past(port_a_direction_in)) == 8'h00))
        else $error("Port A pullup on while pin drives");
    pullup_a_on_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        ##1 (port_a_pullup_out == ($past(port_a_pullup_enable_reg) & ~$past(port_a_direction_in))))
        else $error("Port A pullup does not follow enable");
    pullup_c_off_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        ##1 ((port_c_pullup_out & $past(port_c_direction_reg)) == '0))
        else $error("Port C pullup on while pin drives");
    pullup_c_on_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        ##1 (port_c_pullup_out == ($past(port_c_pullup_enable_reg) & ~$past(port_c_direction_reg))))
        else $error("Port C pullup does not follow enable");
    dir_b_reset_a: assert property (@(posedge clk_sys_in)
        sys_rst_in |=> port_b_direction_reg == 8'h00)
        else $error("Port B direction not cleared by reset");
    dir_c_reset_a: assert property (@(posedge clk_sys_in)
        sys_rst_in |=> port_c_direction_reg == '0 ##1 port_c_pin_oe_n_out == '1 || sys_rst_in)
        else $error("Port C not input after reset");
    analog_force_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        ##1 ((converter_analog_inputs_out & ~port_b_pin_oe_n_out) == 8'h00))
        else $error("Analog pin still driven");
    dir_b_drive_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        s_dir_b_write ##1 (analog_next == 8'h00) |=>
        port_b_pin_oe_n_out == ~$past(wreq_reg.data[7:0], 2))
        else $error("Port B drive does not follow direction");
    read_b_mix_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        s_read_b |=> s_axi_rvalid_out && s_axi_rdata_out[7:0] ==
        (($past(port_b_direction_reg) & $past(port_b_data_latch_reg))
        | (~$past(port_b_direction_reg) & $past(pin_b_sync_reg))))
        else $error("Port B read mixes wrong sources");
    latch_keep_a: assert property (@(posedge clk_sys_in)
        sys_rst_in && !wr_lane0 |=> port_b_data_latch_reg === $past(port_b_data_latch_reg))
        else $error("Port B latch changed by reset");
    bresp_pair_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
        do_write |=> s_axi_bvalid_out)
        else $error("Write response missing");

endmodule

//--- pkg/bpb_map.svh
`ifndef BPB_MAP_SVH
`define BPB_MAP_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define BPB_IDX_PORT_B_DATA 6'h01
`define BPB_IDX_PORT_C_DATA 6'h02
`define BPB_IDX_PORT_B_DIR 6'h05
`define BPB_IDX_PORT_C_DIR 6'h06
`define BPB_IDX_PORT_A_PUE 6'h0D
`define BPB_IDX_PORT_C_PUE 6'h0E

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define BPB_RST_DIR 8'h00
`define BPB_RST_PUE 8'h00
`define BPB_RST_OE_N 8'hFF
`define BPB_RESP_OKAY 2'b00
`define BPB_RESP_SLVERR 2'b10
`define BPB_ADC_PINS 8

`endif

//--- pkg/bpb_pkg.sv
package bpb_pkg;

    // ----------------------------------------------------------------
    // Register selection
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        BPB_SEL_NONE,
        BPB_SEL_B_DATA,
        BPB_SEL_C_DATA,
        BPB_SEL_B_DIR,
        BPB_SEL_C_DIR,
        BPB_SEL_A_PUE,
        BPB_SEL_C_PUE
    } bpb_sel_type;

    // ----------------------------------------------------------------
    // Held write request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] data;
        logic [3:0] strb;
    } bpb_wdata_type;

endpackage

//--- tb/bpb_pin_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Pin level model
// ----------------------------------------------------------------
// An outside driver holds every port B pin, so a pin that the block
// releases shows the outside level. Port C pins may be released by
// the outside as well: a pullup then wins, otherwise the pin settles
// to the inverse of the latch so that a stale value never passes.
module bpb_pin_model (
    // Port B side
    input wire logic [7:0] b_out_in,
    input wire logic [7:0] b_oe_n_in,
    input wire logic [7:0] b_ext_in,
    output logic [7:0] b_pin_out,
    // Port C side
    input wire logic [6:0] c_out_in,
    input wire logic [6:0] c_oe_n_in,
    input wire logic [6:0] c_pullup_in,
    input wire logic [6:0] c_ext_in,
    input wire logic [6:0] c_float_in,
    output logic [6:0] c_pin_out
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            b_pin_out[i] = b_oe_n_in[i] ? b_ext_in[i] : b_out_in[i];
        end
        for (int i = 0; i < 7; i++) begin
            if (!c_oe_n_in[i]) begin
                c_pin_out[i] = c_out_in[i];
            end else if (!c_float_in[i]) begin
                c_pin_out[i] = c_ext_in[i];
            end else begin
                c_pin_out[i] = c_pullup_in[i] ? 1'b1 : ~c_out_in[i];
            end
        end
    end
endmodule

//--- tb/tb_bidir_port_bank_pullups.sv
`timescale 1ns/1ps
`include "bpb_map.svh"
module tb_bidir_port_bank_pullups;
    logic clk_sys_in, sys_rst_in;
    logic [31:0] s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in;
    logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
    logic s_axi_rready_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
    logic s_axi_arready_out, s_axi_rvalid_out;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
    logic [7:0] port_a_direction_in, port_a_pullup_out, port_b_pin_in, port_b_pin_out;
    logic [7:0] port_b_pin_oe_n_out, converter_analog_inputs_out, b_ext, exp_a;
    logic [4:0] adc_channel_in;
    logic [6:0] port_c_pin_in, port_c_pin_out, port_c_pin_oe_n_out, port_c_pullup_out;
    logic [6:0] c_ext, c_float;
    int err_count, total_checks;

    bpb_gpio_ports #(.PORT_C_WIDTH(7), .ADC_CH_WIDTH(5)) uut (
        .clk_sys_in, .sys_rst_in,
        .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
        .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
        .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
        .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
        .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
        .port_a_direction_in, .adc_channel_in, .port_a_pullup_out,
        .port_b_pin_in, .port_b_pin_out, .port_b_pin_oe_n_out, .converter_analog_inputs_out,
        .port_c_pin_in, .port_c_pin_out, .port_c_pin_oe_n_out, .port_c_pullup_out
    );

    bpb_pin_model pins (
        .b_out_in(port_b_pin_out), .b_oe_n_in(port_b_pin_oe_n_out), .b_ext_in(b_ext),
        .b_pin_out(port_b_pin_in), .c_out_in(port_c_pin_out),
        .c_oe_n_in(port_c_pin_oe_n_out), .c_pullup_in(port_c_pullup_out),
        .c_ext_in(c_ext), .c_float_in(c_float), .c_pin_out(port_c_pin_in)
    );

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Both channels are offered together and each is released once taken.
    task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
        @(posedge clk_sys_in);
        s_axi_awaddr_in <= {24'h0000_00, idx, 2'b00};
        s_axi_wdata_in <= {24'h0000_00, d};
        s_axi_wstrb_in <= 4'hF;
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        // Only the watchdog ends a wait that never gets its answer.
        do begin
            @(posedge clk_sys_in);
            if (s_axi_awready_out === 1'b1) s_axi_awvalid_in <= 1'b0;
            if (s_axi_wready_out === 1'b1) s_axi_wvalid_in <= 1'b0;
        end while (s_axi_bvalid_out !== 1'b1);
        s_axi_bready_in <= 1'b0;
        chk({30'h0000_0000, s_axi_bresp_out}, {30'h0000_0000, er});
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] ed, input logic [1:0] er);
        @(posedge clk_sys_in);
        s_axi_araddr_in <= {24'h0000_00, idx, 2'b00};
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do begin
            @(posedge clk_sys_in);
            if (s_axi_arready_out === 1'b1) s_axi_arvalid_in <= 1'b0;
        end while (s_axi_rvalid_out !== 1'b1);
        s_axi_rready_in <= 1'b0;
        chk(s_axi_rdata_out, {24'h0000_00, ed});
        chk({30'h0000_0000, s_axi_rresp_out}, {30'h0000_0000, er});
    endtask

    task automatic complete_run;
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------------------------------
    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    // The tests need under two hundred cycles; twenty thousand can only mean a hang.
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        err_count++;
        complete_run();
    end

    initial begin
        err_count = 0;
        total_checks = 0;
        sys_rst_in = 1'b1;
        {s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in, s_axi_wstrb_in} = '0;
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 3'b000;
        {s_axi_arvalid_in, s_axi_rready_in} = 2'b00;
        port_a_direction_in = 8'h00;
        adc_channel_in = 5'h1F;
        b_ext = 8'h3C;
        c_ext = 7'h00;
        c_float = 7'h7F;
        repeat (3) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        rd_chk(`BPB_IDX_PORT_B_DIR, 8'h00, `BPB_RESP_OKAY);
        rd_chk(`BPB_IDX_PORT_C_DIR, 8'h00, `BPB_RESP_OKAY);
        rd_chk(`BPB_IDX_PORT_A_PUE, 8'h00, `BPB_RESP_OKAY);
        rd_chk(`BPB_IDX_PORT_C_PUE, 8'h00, `BPB_RESP_OKAY);
        chk(port_b_pin_oe_n_out, 8'hFF);
        chk(port_c_pin_oe_n_out, 7'h7F);
        // Latch written while input: pins still read back.
        wr(`BPB_IDX_PORT_B_DATA, 8'hA5, `BPB_RESP_OKAY);
        repeat (4) @(posedge clk_sys_in);
        rd_chk(`BPB_IDX_PORT_B_DATA, 8'h3C, `BPB_RESP_OKAY);
        wr(`BPB_IDX_PORT_B_DIR, 8'h0F, `BPB_RESP_OKAY);
        repeat (4) @(posedge clk_sys_in);
        chk(port_b_pin_oe_n_out, 8'hF0);
        chk(port_b_pin_out, 8'hA5);
        rd_chk(`BPB_IDX_PORT_B_DATA, 8'h35, `BPB_RESP_OKAY);
        rd_chk(`BPB_IDX_PORT_B_DIR, 8'h0F, `BPB_RESP_OKAY);
        wr(`BPB_IDX_PORT_B_DATA, 8'h5A, `BPB_RESP_OKAY);
        rd_chk(`BPB_IDX_PORT_B_DATA, 8'h3A, `BPB_RESP_OKAY);
        // Channel values 0 to 9, two of them beyond the pin count.
        wr(`BPB_IDX_PORT_B_DIR, 8'hFF, `BPB_RESP_OKAY);
        for (int ch = 0; ch < 10; ch++) begin
            adc_channel_in <= ch[4:0];
            repeat (3) @(posedge clk_sys_in);
            exp_a = (ch < 8) ? (8'h01 << ch) : 8'h00;
            chk(converter_analog_inputs_out, exp_a);
            chk(port_b_pin_oe_n_out, exp_a);
        end
        adc_channel_in <= 5'h1F;
        wr(`BPB_IDX_PORT_A_PUE, 8'hA5, `BPB_RESP_OKAY);
        for (int k = 0; k < 3; k++) begin
            exp_a = (k == 0) ? 8'h0F : ((k == 1) ? 8'hF0 : 8'h00);
            port_a_direction_in <= exp_a;
            repeat (3) @(posedge clk_sys_in);
            chk(port_a_pullup_out, 8'hA5 & ~exp_a);
        end
        // Port C: two outputs, the rest released and pulled up.
        wr(`BPB_IDX_PORT_C_DATA, 8'h55, `BPB_RESP_OKAY);
        wr(`BPB_IDX_PORT_C_PUE, 8'h7F, `BPB_RESP_OKAY);
        wr(`BPB_IDX_PORT_C_DIR, 8'h03, `BPB_RESP_OKAY);
        repeat (4) @(posedge clk_sys_in);
        chk(port_c_pullup_out, 7'h7C);
        chk(port_c_pin_oe_n_out, 7'h7C);
        chk(port_c_pin_out, 7'h55);
        rd_chk(`BPB_IDX_PORT_C_DATA, 8'h7D, `BPB_RESP_OKAY);
        rd_chk(`BPB_IDX_PORT_C_PUE, 8'h7F, `BPB_RESP_OKAY);
        wr(`BPB_IDX_PORT_C_PUE, 8'h00, `BPB_RESP_OKAY);
        repeat (4) @(posedge clk_sys_in);
        chk(port_c_pullup_out, 7'h00);
        rd_chk(`BPB_IDX_PORT_C_DATA, 8'h29, `BPB_RESP_OKAY);
        wr(6'h3F, 8'hFF, `BPB_RESP_SLVERR);
        rd_chk(6'h3F, 8'h00, `BPB_RESP_SLVERR);
        // A second reset clears control but keeps the latches.
        @(posedge clk_sys_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        sys_rst_in <= 1'b0;
        @(posedge clk_sys_in);
        chk(port_b_pin_oe_n_out, 8'hFF);
        chk(port_c_pin_oe_n_out, 7'h7F);
        wr(`BPB_IDX_PORT_B_DIR, 8'hFF, `BPB_RESP_OKAY);
        rd_chk(`BPB_IDX_PORT_B_DATA, 8'h5A, `BPB_RESP_OKAY);
        wr(`BPB_IDX_PORT_C_DIR, 8'h7F, `BPB_RESP_OKAY);
        rd_chk(`BPB_IDX_PORT_C_DATA, 8'h55, `BPB_RESP_OKAY);
        complete_run();
    end
endmodule
